// File: src/csr_defs.svh
/*
  constants for the core special register block: register byte offsets,
  field positions, reset values and the data-memory map.
  assumes inclusion by bare name from the design module, the checker and the bench.
*/
`ifndef CSR_DEFS_SVH
`define CSR_DEFS_SVH

// ---------------------------------------------------------------------
// axi register byte offsets
// ---------------------------------------------------------------------
`define CSR_OFF_BANK      8'h00
`define CSR_OFF_FLAGS     8'h04
`define CSR_OFF_WORK      8'h08
`define CSR_OFF_PCLOW     8'h0c
`define CSR_OFF_TBLPTR    8'h10
`define CSR_OFF_TBLHIGH   8'h14
`define CSR_OFF_PCFULL    8'h18
`define CSR_OFF_EVENT     8'h1c
`define CSR_OFF_ALUOP     8'h20
`define CSR_OFF_ALUIN     8'h24
`define CSR_OFF_DIRECT    8'h28
`define CSR_OFF_ROMDATA   8'h2c
`define CSR_OFF_TBLLOW    8'h30
`define CSR_OFF_RAMPTR    8'h34
`define CSR_OFF_RAMDATA   8'h38
`define CSR_OFF_STALL     8'h3c

// ---------------------------------------------------------------------
// fields
// ---------------------------------------------------------------------
`define CSR_FLG_C         0
`define CSR_FLG_AC        1
`define CSR_FLG_Z         2
`define CSR_FLG_OV        3
`define CSR_FLG_SLEEP     4
`define CSR_FLG_DOG       5
`define CSR_FLG_WMASK     8'h0f
`define CSR_BANK_MASK     8'h01
`define CSR_EV_DOG        0
`define CSR_EV_CLRWDT     1
`define CSR_EV_HALT       2
`define CSR_EV_POWERUP    3
`define CSR_EV_CALL       4

// ---------------------------------------------------------------------
// reset values and memory map
// ---------------------------------------------------------------------
`define CSR_RST_BANK      1'b0
`define CSR_RST_FLAGS     8'h00
`define CSR_RST_PC        11'h000
`define CSR_SFR_TOP       8'h3f
`define CSR_BANK1_TOP     8'h4f
`define CSR_DUMMY_CYCLES  2'h1
`define CSR_AXI_OKAY      2'b00
`define CSR_AXI_SLVERR    2'b10

`endif

// File: src/csr_pkg.sv
/*
  types for the core special register block.
  assumes csr_defs.svh is on the include path.
*/
package csr_pkg;
  // alu operations selectable by software
  typedef enum logic [2:0] {
    CSR_OP_ADD, CSR_OP_SUB, CSR_OP_AND, CSR_OP_OR,
    CSR_OP_XOR, CSR_OP_RLC, CSR_OP_RRC, CSR_OP_MOV
  } csr_op_e;
  // fetch sequence for a jump
  typedef enum logic [1:0] {
    CSR_RUN, CSR_DUMMY
  } csr_state_e;
endpackage

// File: src/csr_core_regs.sv
/*
  core special register block: bank pointer, work register, program
  counter low byte, table pointer and high byte, status flags, with a
  small alu and bank-mapped data ram, all under an axi4-lite slave.
  assumes one 250 mhz clock, synchronous active-low reset, and a separate
  power-up reset strobe and sleep-mode wake reason from the system.
*/
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "csr_defs.svh"

module csr_core_regs
  import csr_pkg::*;
(
  input  wire logic        aclk,          // system clock
  input  wire logic        aresetn,       // sync reset, active low
  input  wire logic        power_up,      // reset is a power-up
  input  wire logic        sleep_dog_rst, // reset is dog expiry in sleep
  input  wire logic [7:0]  awaddr,        // write address
  input  wire logic        awvalid,       // write address valid
  output logic             awready,       // write address ready
  input  wire logic [31:0] wdata,         // write data
  input  wire logic [3:0]  wstrb,         // write byte strobes
  input  wire logic        wvalid,        // write data valid
  output logic             wready,        // write data ready
  output logic [1:0]       bresp,         // write response
  output logic             bvalid,        // write response valid
  input  wire logic        bready,        // write response ready
  input  wire logic [7:0]  araddr,        // read address
  input  wire logic        arvalid,       // read address valid
  output logic             arready,       // read address ready
  output logic [31:0]      rdata,         // read data
  output logic [1:0]       rresp,         // read response
  output logic             rvalid,        // read data valid
  input  wire logic        rready,        // read data ready
  output logic [10:0]      prog_counter,  // program counter
  output logic             dummy_cycle    // fetch stalled for a jump
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  logic        bank_reg;               // bank pointer bit
  logic [7:0]  flags_reg;              // status flags
  logic [7:0]  work_reg;               // work register
  logic [10:0] pc_reg;                 // program counter
  logic [7:0]  tblptr_reg;             // table pointer
  logic [7:0]  tblhigh_reg;            // table high byte
  logic [7:0]  tbllow_reg;             // low byte landing location
  logic [15:0] romdata_reg;            // word presented by program rom
  logic [7:0]  ramptr_reg;             // pointer one
  logic [2:0]  aluop_reg;              // selected alu operation
  logic [7:0]  direct_reg;             // direct-address for alu operand
  logic [7:0]  ram [0:255];            // bank 0 data ram
  logic [7:0]  ram1 [64:79];           // bank 1 general ram
  csr_state_e  state_reg;              // fetch state
  logic        aw_reg;                 // write address held
  logic        w_reg;                  // write data held
  logic [7:0]  awaddr_reg;             // held write address
  logic [31:0] wdata_reg;              // held write data
  logic [3:0]  wstrb_reg;              // held write strobes

  // -------------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------------
  function automatic logic csr_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    csr_hit = (a[7:2] == off[7:2]);
  endfunction

  // ram address as seen from a pointer, bank applied
  function automatic logic csr_in_bank1(input logic b,
                                        input logic [7:0] a);
    csr_in_bank1 = b && (a > `CSR_SFR_TOP);
  endfunction

  wire        wr_go = aw_reg && w_reg && !bvalid;   // both halves taken
  wire [7:0]  wa    = awaddr_reg;
  wire        wlow  = wstrb_reg[0];                  // low byte lane
  wire [7:0]  wd    = wdata_reg[7:0];
  wire        wr_bank   = wr_go && wlow && csr_hit(wa, `CSR_OFF_BANK);
  wire        wr_flags  = wr_go && wlow && csr_hit(wa, `CSR_OFF_FLAGS);
  wire        wr_work   = wr_go && wlow && csr_hit(wa, `CSR_OFF_WORK);
  wire        wr_pcl    = wr_go && wlow && csr_hit(wa, `CSR_OFF_PCLOW);
  wire        wr_table_pointer   = wr_go && wlow && csr_hit(wa, `CSR_OFF_TBLPTR);
  wire        wr_event  = wr_go && wlow && csr_hit(wa, `CSR_OFF_EVENT);
  wire        wr_aluop  = wr_go && wlow && csr_hit(wa, `CSR_OFF_ALUOP);
  wire        wr_aluin  = wr_go && wlow && csr_hit(wa, `CSR_OFF_ALUIN);
  wire        wr_direct = wr_go && wlow && csr_hit(wa, `CSR_OFF_DIRECT);
  wire        wr_rom    = wr_go && csr_hit(wa, `CSR_OFF_ROMDATA);
  wire        wr_ramptr = wr_go && wlow && csr_hit(wa, `CSR_OFF_RAMPTR);
  wire        wr_ramdat = wr_go && wlow && csr_hit(wa, `CSR_OFF_RAMDATA);
  wire        wr_tblrd  = wr_go && csr_hit(wa, `CSR_OFF_TBLHIGH);
  wire        wr_known  = wa <= `CSR_OFF_STALL;

  // -------------------------------------------------------------------
  // alu: every result lands in the work register
  // -------------------------------------------------------------------
  // a direct-address write runs the op on bank 0, whatever the pointer
  wire [7:0] opnd   = ram[wd];
  wire       alu_go = wr_aluin || wr_direct;
  wire [7:0] bsrc   = wr_aluin ? wd : opnd;
  wire [7:0] bsub = ~bsrc;
  wire       sub  = (aluop_reg == CSR_OP_SUB);
  wire [7:0] bin  = sub ? bsub : bsrc;
  wire       cin  = sub;               // subtract as a + ~b + 1
  wire [4:0] lo   = {1'b0, work_reg[3:0]} + {1'b0, bin[3:0]}
                    + {4'h0, cin};
  wire [3:0] hi7  = {1'b0, work_reg[6:4]} + {1'b0, bin[6:4]}
                    + {3'h0, lo[4]};
  wire [8:0] sum  = {1'b0, work_reg} + {1'b0, bin} + {8'h00, cin};
  logic [7:0] res;
  logic       arith;
  logic       rot;
  logic       rcarry;
  always_comb begin
    res    = sum[7:0];
    arith  = 1'b0;
    rot    = 1'b0;
    rcarry = flags_reg[`CSR_FLG_C];
    unique case (csr_op_e'(aluop_reg))
      CSR_OP_ADD, CSR_OP_SUB: arith = 1'b1;
      CSR_OP_AND: res = work_reg & bsrc;
      CSR_OP_OR:  res = work_reg | bsrc;
      CSR_OP_XOR: res = work_reg ^ bsrc;
      CSR_OP_RLC: begin
        res    = {bsrc[6:0], flags_reg[`CSR_FLG_C]};
        rot    = 1'b1;
        rcarry = bsrc[7];
      end
      CSR_OP_RRC: begin
        res    = {flags_reg[`CSR_FLG_C], bsrc[7:1]};
        rot    = 1'b1;
        rcarry = bsrc[0];
      end
      CSR_OP_MOV: res = bsrc;           // transfer via work register
    endcase
  end

  // -------------------------------------------------------------------
  // status flags
  // -------------------------------------------------------------------
  logic [7:0] flags_next;
  always_comb begin
    flags_next = flags_reg;
    if (wr_flags) begin
      // software may only reach the arithmetic bits
      flags_next[3:0] = wd[3:0];
    end
    if (alu_go) begin
      if (arith) begin
        flags_next[`CSR_FLG_C]  = sum[8];
        flags_next[`CSR_FLG_AC] = lo[4];
        flags_next[`CSR_FLG_OV] = hi7[3] ^ sum[8];
      end
      if (rot) flags_next[`CSR_FLG_C] = rcarry;
      if (!rot) flags_next[`CSR_FLG_Z] = (res == 8'h00);
    end
    // call entry (event bit four) is ignored: flags are never saved
    if (wr_event) begin
      if (wd[`CSR_EV_CLRWDT]) begin
        flags_next[`CSR_FLG_DOG]   = 1'b0;
        flags_next[`CSR_FLG_SLEEP] = 1'b0;
      end
      if (wd[`CSR_EV_HALT]) begin
        flags_next[`CSR_FLG_DOG]   = 1'b0;
        flags_next[`CSR_FLG_SLEEP] = 1'b1;
      end
      if (wd[`CSR_EV_POWERUP]) begin
        flags_next[`CSR_FLG_DOG]   = 1'b0;
        flags_next[`CSR_FLG_SLEEP] = 1'b0;
      end
      // expiry is set last so it wins over a clear in the same cycle
      if (wd[`CSR_EV_DOG]) flags_next[`CSR_FLG_DOG] = 1'b1;
    end
    flags_next[7:6] = 2'b00;
  end

  // flags hold through ordinary resets; power-up clears them all
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      if (power_up) flags_reg <= `CSR_RST_FLAGS;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // -------------------------------------------------------------------
  // bank pointer
  // -------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      if (!sleep_dog_rst || power_up) bank_reg <= `CSR_RST_BANK;
    end else if (wr_bank) begin
      bank_reg <= wd[0];
    end
  end

  // -------------------------------------------------------------------
  // work register, table registers, pointers
  // -------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      work_reg    <= 8'h00;
      tblptr_reg  <= 8'h00;
      tblhigh_reg <= 8'h00;
      tbllow_reg  <= 8'h00;
      romdata_reg <= 16'h0000;
      ramptr_reg  <= 8'h00;
      aluop_reg   <= 3'h0;
      direct_reg  <= 8'h00;
    end else begin
      if (alu_go) work_reg <= res;
      else if (wr_work) work_reg <= wd;
      if (wr_table_pointer) tblptr_reg <= wd;
      if (wr_rom) romdata_reg <= wdata_reg[15:0];
      if (wr_tblrd) begin
        tblhigh_reg <= romdata_reg[15:8];
        tbllow_reg  <= romdata_reg[7:0];
      end
      if (wr_ramptr) ramptr_reg <= wd;
      if (wr_aluop) aluop_reg <= wd[2:0];
      if (wr_direct) direct_reg <= wd;
    end
  end

  // bank 1 reached only through pointer one
  wire ind_b1 = csr_in_bank1(bank_reg, ramptr_reg);
  wire ind_ok = !bank_reg || ramptr_reg <= `CSR_BANK1_TOP;
  always_ff @(posedge aclk) begin
    if (wr_ramdat && ind_ok) begin
      if (ind_b1) ram1[ramptr_reg] <= wd;
      else ram[ramptr_reg] <= wd;
    end
  end

  // -------------------------------------------------------------------
  // program counter and jump stall
  // -------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_reg    <= `CSR_RST_PC;
      state_reg <= CSR_RUN;
    end else if (wr_pcl) begin
      pc_reg    <= {pc_reg[10:8], wd};
      state_reg <= CSR_DUMMY;
    end else begin
      unique case (state_reg)
        CSR_RUN:   pc_reg <= pc_reg + 11'h001;
        CSR_DUMMY: state_reg <= CSR_RUN;
      endcase
    end
  end
  assign prog_counter = pc_reg;
  assign dummy_cycle  = (state_reg == CSR_DUMMY);

  // -------------------------------------------------------------------
  // axi write channel
  // -------------------------------------------------------------------
  assign awready = !aw_reg;
  assign wready  = !w_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg     <= 1'b0;
      w_reg      <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= `CSR_AXI_OKAY;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0;
      wstrb_reg  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_reg     <= 1'b1;
        awaddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_reg     <= 1'b1;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (wr_go) begin
        aw_reg <= 1'b0;
        w_reg  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= wr_known ? `CSR_AXI_OKAY : `CSR_AXI_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // axi read channel
  // -------------------------------------------------------------------
  wire [7:0] ra = araddr;
  wire ind_rb1 = csr_in_bank1(bank_reg, ramptr_reg);
  wire [7:0] ram_rd = !ind_ok ? 8'h00 :
                      ind_rb1 ? ram1[ramptr_reg] : ram[ramptr_reg];
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (ra[7:2])
      6'h00: rd_mux[7:0] = {7'h00, bank_reg};
      6'h01: rd_mux[7:0] = flags_reg;
      6'h02: rd_mux[7:0] = work_reg;
      6'h03: rd_mux[7:0] = pc_reg[7:0];
      6'h04: rd_mux[7:0] = tblptr_reg;
      6'h05: rd_mux[7:0] = tblhigh_reg;
      6'h06: rd_mux[10:0] = pc_reg;
      6'h08: rd_mux[2:0] = aluop_reg;
      6'h0a: rd_mux[7:0] = direct_reg;
      6'h0b: rd_mux[15:0] = romdata_reg;
      6'h0c: rd_mux[7:0] = tbllow_reg;
      6'h0d: rd_mux[7:0] = ramptr_reg;
      6'h0e: rd_mux[7:0] = ram_rd;
      6'h0f: rd_mux[0] = dummy_cycle;
      default: rd_mux = 32'h0;
    endcase
  end
  assign arready = !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= `CSR_AXI_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= (ra <= `CSR_OFF_STALL) ? `CSR_AXI_OKAY : `CSR_AXI_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// File: test/csr_core_regs_props.sv
/*
  checker for csr_core_regs: axi handshakes, read fields, jump stall.
  assumes the design top's ports and csr_defs.svh on the include path.
*/
`timescale 1ns/1ps
`include "csr_defs.svh"

module csr_core_regs_props (
  input wire logic        aclk,         // clock
  input wire logic        aresetn,      // sync reset, active low
  input wire logic [7:0]  araddr,       // read address
  input wire logic        arvalid,      // read address valid
  input wire logic        arready,      // read address ready
  input wire logic [31:0] rdata,        // read data
  input wire logic [1:0]  rresp,        // read response
  input wire logic        rvalid,       // read data valid
  input wire logic        rready,       // read data ready
  input wire logic [1:0]  bresp,        // write response
  input wire logic        bvalid,       // write response valid
  input wire logic        bready,       // write response ready
  input wire logic [10:0] prog_counter, // program counter
  input wire logic        dummy_cycle   // jump stall
);
  // ---------------------------------------------------------------
  // helper: address of the read in flight
  // ---------------------------------------------------------------
  logic [7:0] rd_addr_reg; // held until the next read is taken
  always_ff @(posedge aclk) begin
    if (arvalid && arready) rd_addr_reg <= araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_reset_idle;
    $rose(aresetn) |-> !bvalid && !rvalid && prog_counter == 11'h000;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  property p_rd_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read answer dropped or changed");
  property p_wr_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write answer dropped or changed");
  property p_ar_answer;
    arvalid && arready |=> rvalid;
  endproperty
  a_ar_answer: assert property (p_ar_answer)
    else $error("read answer late");
  property p_ar_block;
    rvalid |-> !arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read address taken while answer pending");
  property p_dummy_one;
    dummy_cycle |=> !dummy_cycle;
  endproperty
  a_dummy_one: assert property (p_dummy_one)
    else $error("jump stall longer than one cycle");
  property p_dummy_hold;
    dummy_cycle |=> $stable(prog_counter);
  endproperty
  a_dummy_hold: assert property (p_dummy_hold)
    else $error("program counter moved during jump stall");
  property p_bank_read;
    rvalid && rd_addr_reg == `CSR_OFF_BANK |-> rdata[31:1] == 31'h0;
  endproperty
  a_bank_read: assert property (p_bank_read)
    else $error("bank pointer upper bits not zero");
  property p_flag_read;
    rvalid && rd_addr_reg == `CSR_OFF_FLAGS |-> rdata[31:6] == 26'h0;
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("flags upper bits not zero");
  property p_unmapped;
    rvalid && rd_addr_reg > 8'h3c |-> rresp == `CSR_AXI_SLVERR
      && rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
endmodule

bind csr_core_regs csr_core_regs_props u_props (.aclk(aclk),
  .aresetn(aresetn), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .prog_counter(prog_counter), .dummy_cycle(dummy_cycle));

// File: test/tb_csr_core_regs.sv
/*
  self-checking bench for csr_core_regs over axi4-lite.
  assumes csr_defs.svh on the include path and the bound checker.
*/
`timescale 1ns/1ps
`include "csr_defs.svh"

module tb_csr_core_regs;
  logic aclk = 0, aresetn = 0, power_up = 1, sleep_dog_rst = 0;
  logic [7:0] awaddr = 0, araddr = 0, rnd = 8'h2e, a, b;
  logic [31:0] wdata = 0, d, rdata;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, dummy_cycle;
  logic [1:0] bresp, rresp, r;
  logic [10:0] prog_counter, p0;
  int num_errors = 0, check_count = 0;
  int dummy_seen = 0, n0; // cycles with the jump stall shown

  csr_core_regs dut (.aclk(aclk), .aresetn(aresetn), .power_up(power_up),
    .sleep_dog_rst(sleep_dog_rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .prog_counter(prog_counter), .dummy_cycle(dummy_cycle));

  initial begin
    forever #2 aclk = ~aclk;
  end
  // count the cycles in which the jump stall is shown
  always @(posedge aclk) begin
    if (dummy_cycle === 1'b1) dummy_seen <= dummy_seen + 1;
  end
  // next pseudo-random byte
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // expected ov, z, ac, c of an add, or of a subtract (c = no borrow)
  function automatic logic [31:0] add_flags(input logic [7:0] x, y,
                                            input logic sb);
    logic [8:0] s;
    logic [7:0] l, df;
    logic [4:0] h;
    logic       c, ac, ov, z;
    s  = x + y;
    l  = x[6:0] + y[6:0];
    h  = x[3:0] + y[3:0];
    df = x - y;
    c  = sb ? (x >= y) : s[8];
    ac = sb ? (x[3:0] >= y[3:0]) : h[4];
    ov = sb ? (x[7] ^ y[7]) & (df[7] ^ x[7]) : l[7] ^ s[8];
    z  = sb ? (df == 8'h00) : (s[7:0] == 8'h00);
    return {28'h0, ov, z, ac, c};
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic ck(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic hang;
    $display("MISMATCH axi wait expected answer seen timeout");
    num_errors++;
    tally_and_finish;
  endtask
  // one axi write, response kept in r
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    logic ah, wh, bh;
    bh = 0;
    @(posedge aclk);
    awaddr <= ad; wdata <= v; wstrb <= 4'hf;
    awvalid <= 1; wvalid <= 1; bready <= 1;
    for (int n = 0; n < 40 && !bh; n++) begin
      #1;
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 0;
      if (wh) wvalid <= 0;
      if (bh) bready <= 0;
    end
    if (!bh) hang();
  endtask
  // one axi read, data in d and response in r
  task automatic rd(input logic [7:0] ad);
    logic ah, rh;
    rh = 0;
    @(posedge aclk);
    araddr <= ad; arvalid <= 1; rready <= 1;
    for (int n = 0; n < 40 && !rh; n++) begin
      #1;
      ah = arvalid && arready;
      rh = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 0;
      if (rh) rready <= 0;
    end
    if (!rh) hang();
  endtask
  task automatic rc(input logic [7:0] ad, input logic [31:0] e);
    rd(ad);
    ck("register", e, d);
  endtask
  task automatic rst(input logic pu, sd);
    @(posedge aclk);
    aresetn <= 0; power_up <= pu; sleep_dog_rst <= sd;
    repeat (4) @(posedge aclk);
    aresetn <= 1; power_up <= 0; sleep_dog_rst <= 0;
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    power_up <= 0;
    // reset values, bank bit and unmapped place
    rc(`CSR_OFF_BANK, 32'h0);
    rc(`CSR_OFF_FLAGS, 32'h0);
    wr(`CSR_OFF_BANK, 32'hff);
    rc(`CSR_OFF_BANK, 32'h1);
    wr(8'h40, 32'h1);
    ck("bresp", `CSR_AXI_SLVERR, r);
    rd(8'h40);
    ck("rresp", `CSR_AXI_SLVERR, r);
    rst(0, 1);
    rc(`CSR_OFF_BANK, 32'h1);
    rst(0, 0);
    rc(`CSR_OFF_BANK, 32'h0);
    $display("test bank done");
    // flags: software writes and system events
    wr(`CSR_OFF_FLAGS, 32'hff);
    rc(`CSR_OFF_FLAGS, 32'h0f);
    wr(`CSR_OFF_EVENT, 32'h01);
    wr(`CSR_OFF_FLAGS, 32'h05);
    rc(`CSR_OFF_FLAGS, 32'h25);
    wr(`CSR_OFF_EVENT, 32'h04);
    rc(`CSR_OFF_FLAGS, 32'h15);
    wr(`CSR_OFF_EVENT, 32'h10);
    rc(`CSR_OFF_FLAGS, 32'h15);
    wr(`CSR_OFF_EVENT, 32'h02);
    rc(`CSR_OFF_FLAGS, 32'h05);
    wr(`CSR_OFF_EVENT, 32'h05);
    wr(`CSR_OFF_EVENT, 32'h08);
    rd(`CSR_OFF_FLAGS);
    ck("dog sleep", 32'h0, d & 32'h30);
    $display("test flags done");
    // alu add and subtract with corners then random operands
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      a = (i == 0) ? 8'h80 : (i == 1) ? 8'hff : (i == 2) ? 8'h7f : rnd;
      rnd = lfsr(rnd);
      b = (i == 0) ? 8'h80 : (i < 3) ? 8'h01 : rnd;
      wr(`CSR_OFF_ALUOP, 32'h7);
      wr(`CSR_OFF_ALUIN, {24'h0, a});
      // add on even passes, subtract on odd ones
      wr(`CSR_OFF_ALUOP, {31'h0, i[0]});
      wr(`CSR_OFF_ALUIN, {24'h0, b});
      rc(`CSR_OFF_WORK, {24'h0, i[0] ? a - b : a + b});
      rd(`CSR_OFF_FLAGS);
      ck("alu flags", add_flags(a, b, i[0]), d & 32'h0f);
    end
    wr(`CSR_OFF_ALUOP, 32'h2);
    wr(`CSR_OFF_ALUIN, 32'h0);
    rd(`CSR_OFF_FLAGS);
    ck("zero flag", 32'h4, d & 32'h4);
    wr(`CSR_OFF_ALUOP, 32'h3);
    wr(`CSR_OFF_ALUIN, 32'h42);
    rc(`CSR_OFF_WORK, 32'h42);
    rd(`CSR_OFF_FLAGS);
    ck("or nonzero", 32'h0, d & 32'h4);
    wr(`CSR_OFF_ALUOP, 32'h4);
    wr(`CSR_OFF_ALUIN, 32'h42);
    rd(`CSR_OFF_FLAGS);
    ck("xor zero", 32'h4, d & 32'h4);
    // rotates through carry: carry in 1, then out 0
    wr(`CSR_OFF_FLAGS, 32'h1);
    wr(`CSR_OFF_ALUOP, 32'h5);
    wr(`CSR_OFF_ALUIN, 32'h80);
    rc(`CSR_OFF_WORK, 32'h01);
    wr(`CSR_OFF_ALUOP, 32'h6);
    wr(`CSR_OFF_ALUIN, 32'h02);
    rc(`CSR_OFF_WORK, 32'h81);
    rd(`CSR_OFF_FLAGS);
    ck("rotate carry", 32'h0, d & 32'h1);
    $display("test alu done");
    // indirect access across banks
    wr(`CSR_OFF_BANK, 32'h0);
    wr(`CSR_OFF_RAMPTR, 32'h48);
    wr(`CSR_OFF_RAMDATA, 32'ha5);
    wr(`CSR_OFF_BANK, 32'h1);
    wr(`CSR_OFF_RAMDATA, 32'h5a);
    rc(`CSR_OFF_RAMDATA, 32'h5a);
    wr(`CSR_OFF_BANK, 32'h0);
    rc(`CSR_OFF_RAMDATA, 32'ha5);
    wr(`CSR_OFF_RAMPTR, 32'h60);
    wr(`CSR_OFF_BANK, 32'h1);
    wr(`CSR_OFF_RAMDATA, 32'h33);
    rc(`CSR_OFF_RAMDATA, 32'h0);
    // direct operand comes from bank 0 although bank 1 is selected
    wr(`CSR_OFF_ALUOP, 32'h7);
    wr(`CSR_OFF_DIRECT, 32'h48);
    rc(`CSR_OFF_WORK, 32'ha5);
    // special area is shared by both banks
    wr(`CSR_OFF_RAMPTR, 32'h10);
    wr(`CSR_OFF_RAMDATA, 32'h77);
    wr(`CSR_OFF_BANK, 32'h0);
    rc(`CSR_OFF_RAMDATA, 32'h77);
    $display("test indirect done");
    // table read splits the word
    rnd = lfsr(rnd);
    a = rnd;
    rnd = lfsr(rnd);
    wr(`CSR_OFF_TBLPTR, {24'h0, rnd});
    wr(`CSR_OFF_ROMDATA, {16'h0, a, rnd});
    wr(`CSR_OFF_TBLHIGH, 32'h0);
    rc(`CSR_OFF_TBLHIGH, {24'h0, a});
    rc(`CSR_OFF_TBLLOW, {24'h0, rnd});
    $display("test table done");
    // jump by low byte stays in page
    for (int i = 0; i < 40; i++) begin
      rd(`CSR_OFF_PCFULL);
      p0 = d[10:0];
      if (p0[7:0] < 8'hc0) begin
        n0 = dummy_seen;
        wr(`CSR_OFF_PCLOW, 32'h20);
        rd(`CSR_OFF_PCFULL);
        ck("dummy cycles", 32'h1, dummy_seen - n0);
        ck("pc page", {29'h0, p0[10:8]}, {29'h0, d[10:8]});
        ck("pc low", 32'h1, {31'h0, d[7:5] == 3'h1});
        break;
      end
    end
    $display("test jump done");
    tally_and_finish;
  end
endmodule
